// ===== rtl/fsr_pkg.sv
// Package: register map, field layout and constants of the fault status block
package fsr_pkg;
  // ----------------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------------
  localparam logic [3:0] OFS_FAULT_CTRL   = 4'h0;
  localparam logic [3:0] OFS_CTRL_INV     = 4'h4;
  localparam logic [3:0] OFS_MON_LATCHED  = 4'h8;
  localparam logic [3:0] OFS_MON_LIVE     = 4'hc;
  localparam logic [4:0] OFS_IO_ERR       = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK     = 5'h14;
  localparam logic [4:0] OFS_IO_MASK      = 5'h18;
  localparam logic [4:0] OFS_IO_INJECT    = 5'h1c;
  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int CLR_BIT   = 6;
  localparam int CNT_LSB   = 2;
  localparam int CNT_MSB   = 5;
  localparam int LIM_MSB   = 1;
  localparam int IO_B_BIT  = 14;
  localparam int IO_A_BIT  = 13;
  localparam int MON_BITS  = 15;
  localparam logic [15:0] MON_MASK = 16'h7fff;
  localparam logic [15:0] IO_MASK  = 16'h6000;
  // ----------------------------------------------------------------------------
  // Reset values and limit decode
  // ----------------------------------------------------------------------------
  localparam logic [15:0] RST16    = 16'h0000;
  localparam logic [1:0]  RST_LIM  = 2'h0;
  localparam logic [3:0]  RST_CNT  = 4'h0;
  localparam logic [3:0]  CNT_ONE  = 4'h1;
  localparam logic [3:0]  MAX_L0   = 4'h1;
  localparam logic [3:0]  MAX_L1   = 4'h2;
  localparam logic [3:0]  MAX_L2   = 4'h6;
  localparam logic [3:0]  MAX_L3   = 4'hc;
  localparam logic [1:0]  LIM_C0   = 2'h0;
  localparam logic [1:0]  LIM_C1   = 2'h1;
  localparam logic [1:0]  LIM_C2   = 2'h2;
endpackage

// ===== rtl/fsr_regs.sv
// Fault status register slice with Wishbone slave and interrupt
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Inverse register bit 6 holds complement of the counter clear command.
// [RULE2] Inverse register bits 1:0 hold inverted copy of the counter limit.
// [RULE3] New counter limit applies only when it equals inverse of inverted field.
// [RULE4] Limit codes 00,01,10,11 decode to maximum counts 1,2,6,12.
// [RULE5] Writing one to clear command resets the counter, then self-clears.
// [RULE6] Latched bit 14 sets when second switcher hits current limit.
// [RULE7] Latched bit 13 sets when first switcher hits current limit.
// [RULE8] Latched bit 12 sets on thermal shutdown.
// [RULE9] Latched undervoltage bits 11..6: switcher b, a, monitors d..a.
// [RULE10] Latched overvoltage bits 5..0: switcher b, a, monitors d..a.
// [RULE11] Live bits 14 and 13 follow present switcher current limits.
// [RULE12] Live bit 12 follows present thermal shutdown.
// [RULE13] Live bits 11..6 follow present undervoltage, same ordering.
// [RULE14] Live bits 5..0 follow present overvoltage, same ordering.
// [RULE15] IO error bits 14 and 13 set on fault input b and a errors.
// [RULE16] Every field resets to zero on power-on reset only.
// [RULE17] Latched flag sets while live condition is high, stays until cleared.
// [RULE18] Software writing one to a latched flag clears it.
module fsr_regs (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic             wb_ack_o,
  input  wire logic [14:0] monitorCond,
  input  wire logic        faultInAError,
  input  wire logic        faultInBError,
  input  wire logic        faultEvent,
  output logic      [3:0]  faultCountValue,
  output logic      [3:0]  faultCountMax,
  output logic             faultCountReached,
  output logic             irq
);
  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic [17:0] syncMeta;
  logic [17:0] syncOut;
  logic [17:0] next_syncMeta;
  logic [17:0] next_syncOut;
  logic [14:0] liveCond;
  logic        faultInA;
  logic        faultInB;
  logic        faultEvt;
  logic        faultEvtLast;
  logic        next_faultEvtLast;

  always_comb begin
    next_syncMeta     = {faultEvent, faultInBError, faultInAError, monitorCond};
    next_syncOut      = syncMeta;
    next_faultEvtLast = syncOut[17];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      syncMeta     <= 18'h00000;
      syncOut      <= 18'h00000;
      faultEvtLast <= 1'b0;
    end else begin
      syncMeta     <= next_syncMeta;
      syncOut      <= next_syncOut;
      faultEvtLast <= next_faultEvtLast;
    end
  end

  assign liveCond = syncOut[14:0]; // RULE11 RULE12 RULE13 RULE14
  assign faultInA = syncOut[15];
  assign faultInB = syncOut[16];
  // Edge taken after sync; an event shorter than one clock may be missed
  assign faultEvt = syncOut[17] & ~faultEvtLast;

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  logic [15:0] monLatched;
  logic [15:0] ioErr;
  logic [15:0] irqMask;
  logic [15:0] ioMask;
  logic [1:0]  counterLimit;
  logic [1:0]  invCounterLimit;
  logic        invCounterClear;
  logic        counterClearCmd;
  logic [3:0]  countVal;
  logic        ackQ;
  logic [31:0] rdData;
  logic [15:0] next_monLatched;
  logic [15:0] next_ioErr;
  logic [15:0] next_irqMask;
  logic [15:0] next_ioMask;
  logic [1:0]  next_counterLimit;
  logic [1:0]  next_invCounterLimit;
  logic        next_invCounterClear;
  logic        next_counterClearCmd;
  logic [3:0]  next_countVal;
  logic        next_ackQ;
  logic [31:0] next_rdData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic [15:0] wrData;
  logic        loByte;
  logic        hiByte;
  logic [15:0] liveWord;
  logic [15:0] ioSet;

  assign wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & ~ackQ;
  assign rdStrobe = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ackQ;
  assign loByte   = wb_sel_i[0];
  assign hiByte   = wb_sel_i[1];
  assign wrData   = wb_dat_i[15:0] & {{8{hiByte}}, {8{loByte}}};
  assign liveWord = {1'b0, liveCond};
  assign ioSet    = {1'b0, faultInB, faultInA, 13'h0000} & fsr_pkg::IO_MASK; // RULE15

  always_comb begin
    next_monLatched      = monLatched;
    next_ioErr           = ioErr;
    next_irqMask         = irqMask;
    next_ioMask          = ioMask;
    next_counterLimit    = counterLimit;
    next_invCounterLimit = invCounterLimit;
    next_invCounterClear = invCounterClear;
    next_counterClearCmd = 1'b0; // RULE5
    next_countVal        = countVal;
    next_ackQ            = wb_cyc_i & wb_stb_i & ~ackQ;
    next_rdData          = rdData;
    // Clear first so a coincident event set wins
    if (wrStrobe && wb_adr_i == {1'b0, fsr_pkg::OFS_MON_LATCHED}) begin
      next_monLatched = monLatched & ~wrData; // RULE18
    end
    if (wrStrobe && wb_adr_i == fsr_pkg::OFS_IO_ERR) begin
      next_ioErr = ioErr & ~wrData;
    end
    next_monLatched = (next_monLatched | liveWord) & fsr_pkg::MON_MASK; // RULE6 RULE7 RULE8 RULE9 RULE10 RULE17
    next_ioErr      = next_ioErr | ioSet; // RULE15
    if (wrStrobe && wb_adr_i == fsr_pkg::OFS_IRQ_MASK) begin
      next_irqMask = (wrData | (irqMask & ~{{8{hiByte}}, {8{loByte}}})) & fsr_pkg::MON_MASK;
    end
    if (wrStrobe && wb_adr_i == fsr_pkg::OFS_IO_MASK) begin
      next_ioMask = (wrData | (ioMask & ~{{8{hiByte}}, {8{loByte}}})) & fsr_pkg::IO_MASK;
    end
    if (wrStrobe && loByte && wb_adr_i == {1'b0, fsr_pkg::OFS_CTRL_INV}) begin
      next_invCounterClear = wb_dat_i[fsr_pkg::CLR_BIT];       // RULE1
      next_invCounterLimit = wb_dat_i[fsr_pkg::LIM_MSB:0];     // RULE2
    end
    if (wrStrobe && loByte && wb_adr_i == {1'b0, fsr_pkg::OFS_FAULT_CTRL}) begin
      // Mismatched limit writes are dropped, not partially applied
      if (wb_dat_i[fsr_pkg::LIM_MSB:0] == ~invCounterLimit) begin
        next_counterLimit = wb_dat_i[fsr_pkg::LIM_MSB:0]; // RULE3
      end
      if (wb_dat_i[fsr_pkg::CLR_BIT] && !invCounterClear) begin
        next_counterClearCmd = 1'b1; // RULE1 RULE5
      end
    end
    if (counterClearCmd) begin
      next_countVal = fsr_pkg::RST_CNT; // RULE5
    end else if (faultEvt && countVal < faultCountMax) begin
      // Less-than, so a lowered limit freezes the count instead of wrapping it
      next_countVal = countVal + fsr_pkg::CNT_ONE;
    end
    unique case (wb_adr_i)
      {1'b0, fsr_pkg::OFS_FAULT_CTRL}:
        next_rdData = {25'h0000000, counterClearCmd, countVal, counterLimit};
      {1'b0, fsr_pkg::OFS_CTRL_INV}:
        next_rdData = {25'h0000000, invCounterClear, 4'h0, invCounterLimit};
      {1'b0, fsr_pkg::OFS_MON_LATCHED}: next_rdData = {16'h0000, monLatched};
      {1'b0, fsr_pkg::OFS_MON_LIVE}:    next_rdData = {16'h0000, liveWord};
      fsr_pkg::OFS_IO_ERR:              next_rdData = {16'h0000, ioErr};
      fsr_pkg::OFS_IRQ_MASK:            next_rdData = {16'h0000, irqMask};
      fsr_pkg::OFS_IO_MASK:             next_rdData = {16'h0000, ioMask};
      default:                          next_rdData = 32'h00000000;
    endcase
    if (!rdStrobe) begin
      next_rdData = rdData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin // RULE16
      monLatched      <= fsr_pkg::RST16;
      ioErr           <= fsr_pkg::RST16;
      irqMask         <= fsr_pkg::RST16;
      ioMask          <= fsr_pkg::RST16;
      counterLimit    <= fsr_pkg::RST_LIM;
      invCounterLimit <= fsr_pkg::RST_LIM;
      invCounterClear <= 1'b0;
      counterClearCmd <= 1'b0;
      countVal        <= fsr_pkg::RST_CNT;
      ackQ            <= 1'b0;
      rdData          <= 32'h00000000;
    end else begin
      monLatched      <= next_monLatched;
      ioErr           <= next_ioErr;
      irqMask         <= next_irqMask;
      ioMask          <= next_ioMask;
      counterLimit    <= next_counterLimit;
      invCounterLimit <= next_invCounterLimit;
      invCounterClear <= next_invCounterClear;
      counterClearCmd <= next_counterClearCmd;
      countVal        <= next_countVal;
      ackQ            <= next_ackQ;
      rdData          <= next_rdData;
    end
  end

  // ----------------------------------------------------------------------------
  // Limit decode and outputs
  // ----------------------------------------------------------------------------
  always_comb begin
    unique case (counterLimit) // RULE4
      fsr_pkg::LIM_C0: faultCountMax = fsr_pkg::MAX_L0;
      fsr_pkg::LIM_C1: faultCountMax = fsr_pkg::MAX_L1;
      fsr_pkg::LIM_C2: faultCountMax = fsr_pkg::MAX_L2;
      default:         faultCountMax = fsr_pkg::MAX_L3;
    endcase
  end

  assign faultCountValue   = countVal;
  assign faultCountReached = (countVal == faultCountMax);
  assign wb_ack_o          = ackQ;
  assign wb_dat_o          = rdData;
  assign irq               = |(monLatched & irqMask) | |(ioErr & ioMask);

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  live_tracks_cond_a: assert property (##2 liveWord[14:0] == $past(monitorCond, 2)) // RULE11
    else $error("live word does not follow the pins");
  live_to_latch_a: assert property (##1 ($past(liveWord) & ~monLatched) == // RULE17
      fsr_pkg::RST16)
    else $error("live condition not latched");
  latch_on_live_a: assert property (liveWord[12] |=> monLatched[12]) // RULE8
    else $error("thermal flag not latched");
  latch_holds_a: assert property (monLatched[14] && !liveWord[14] && !(wrStrobe &&
      wb_adr_i == {1'b0, fsr_pkg::OFS_MON_LATCHED} && wrData[14]) |=> monLatched[14]) // RULE17
    else $error("latched flag dropped without clear");
  w1c_clears_a: assert property (wrStrobe && wb_adr_i == {1'b0, fsr_pkg::OFS_MON_LATCHED} &&
      wrData[0] && !liveWord[0] |=> !monLatched[0]) // RULE18
    else $error("write one did not clear flag");
  clear_self_a: assert property (counterClearCmd |=> !counterClearCmd && countVal == fsr_pkg::RST_CNT) // RULE5
    else $error("counter clear not applied or not self-cleared");
  clear_guard_a: assert property (counterClearCmd |-> $past(wb_dat_i[fsr_pkg::CLR_BIT]) && // RULE1
      !$past(invCounterClear))
    else $error("clear applied without inverse bit");
  inv_write_a: assert property (wrStrobe && loByte && // RULE1 RULE2
      wb_adr_i == {1'b0, fsr_pkg::OFS_CTRL_INV} |=>
      invCounterLimit == $past(wb_dat_i[fsr_pkg::LIM_MSB:0]) &&
      invCounterClear == $past(wb_dat_i[fsr_pkg::CLR_BIT]))
    else $error("inverse register write lost");
  limit_guard_a: assert property ($changed(counterLimit) |-> $past(wrStrobe) && // RULE3
      $past(wb_dat_i[fsr_pkg::LIM_MSB:0]) == ~$past(invCounterLimit))
    else $error("limit changed without matching inverse");
  limit_hold_a: assert property (!(wrStrobe && loByte && // RULE3
      wb_adr_i == {1'b0, fsr_pkg::OFS_FAULT_CTRL}) |=> $stable(counterLimit))
    else $error("limit changed without a control write");
  limit_decode_a: assert property (counterLimit == fsr_pkg::LIM_C2 |-> faultCountMax == fsr_pkg::MAX_L2) // RULE4
    else $error("limit decode wrong");
  count_step_a: assert property (faultEvt && !counterClearCmd && // RULE4
      countVal < faultCountMax |=> countVal == $past(countVal) + fsr_pkg::CNT_ONE)
    else $error("fault event not counted");
  count_cap_a: assert property (countVal >= faultCountMax && !counterClearCmd |=> // RULE4
      $stable(countVal))
    else $error("count moved past maximum");
  count_idle_a: assert property (!faultEvt && !counterClearCmd |=> $stable(countVal))
    else $error("count moved without an event");
  io_set_a: assert property (faultInA |=> ioErr[13]) // RULE15
    else $error("io error flag not set");
  io_b_set_a: assert property (faultInB |=> ioErr[14]) // RULE15
    else $error("second io error flag not set");
  io_hold_a: assert property (ioErr[13] && !(wrStrobe && // RULE15
      wb_adr_i == fsr_pkg::OFS_IO_ERR && wrData[13]) |=> ioErr[13])
    else $error("io error flag dropped without clear");
  io_w1c_a: assert property (wrStrobe && wrData[13] && !faultInA && // RULE15
      wb_adr_i == fsr_pkg::OFS_IO_ERR |=> !ioErr[13])
    else $error("write one did not clear io flag");
  mask_write_a: assert property (wrStrobe && &wb_sel_i[1:0] &&
      wb_adr_i == fsr_pkg::OFS_IRQ_MASK |=>
      irqMask == ($past(wb_dat_i[15:0]) & fsr_pkg::MON_MASK))
    else $error("interrupt mask write lost");
  io_mask_write_a: assert property (wrStrobe && &wb_sel_i[1:0] &&
      wb_adr_i == fsr_pkg::OFS_IO_MASK |=>
      ioMask == ($past(wb_dat_i[15:0]) & fsr_pkg::IO_MASK))
    else $error("io mask write lost");
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  live_read_a: assert property (rdStrobe && wb_adr_i == {1'b0, fsr_pkg::OFS_MON_LIVE} |=> // RULE11
      wb_dat_o[15:0] == $past(liveWord))
    else $error("live read data wrong");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  flag_seen_c: cover property (liveWord[9] ##1 monLatched[9] ##[1:20] !monLatched[9]);
  limit_set_c: cover property ($changed(counterLimit) && counterLimit == 2'h3);
  clear_cmd_c: cover property (counterClearCmd);
  irq_rise_c: cover property ($rose(irq));
  io_err_c: cover property ($rose(ioErr[14]));
endmodule
`default_nettype wire

// ===== tb/tb_fsr_regs.sv
// Self-checking testbench of the fault status register slice
`timescale 1ns/1ps
`default_nettype none
module tb_fsr_regs;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  wbAdr = 5'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic        wbWe = 1'b0;
  logic [3:0]  wbSel = 4'h0;
  logic        wbStb = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbAck;
  logic [14:0] monitorCond = 15'h0;
  logic        faultInAError = 1'b0;
  logic        faultInBError = 1'b0;
  logic        faultEvent = 1'b0;
  logic [3:0]  faultCountValue;
  logic [3:0]  faultCountMax;
  logic        faultCountReached;
  logic        irq;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [15:0] lat;
  logic [15:0] cond;
  logic [15:0] msk;
  logic [1:0]  prevLim;
  logic [31:0] seedVal;

  always #50 ref_clk = ~ref_clk;

  fsr_regs dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_stb_i(wbStb),
    .wb_cyc_i(wbCyc), .wb_ack_o(wbAck), .monitorCond(monitorCond),
    .faultInAError(faultInAError), .faultInBError(faultInBError),
    .faultEvent(faultEvent), .faultCountValue(faultCountValue),
    .faultCountMax(faultCountMax), .faultCountReached(faultCountReached), .irq(irq)
  );
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle; slave latency is not assumed, only bounded
  task automatic wb(input logic [4:0] a, input logic w, input logic [15:0] d,
                    output logic [15:0] q);
    int i;
    @(posedge ref_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbAdr  <= a;
    wbWe   <= w;
    wbDatI <= {16'h0, d};
    wbSel  <= 4'h3;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (wbAck !== 1'b1 && i < 20);
    if (wbAck !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    q = wbDatO[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] q;
    wb(a, 1'b0, 16'h0, q);
    chk(what, q, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(a, 1'b1, d, q);
  endtask

  // Two-flop input sync plus latch update
  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic pulse();
    faultEvent <= 1'b1;
    settle();
    faultEvent <= 1'b0;
    settle();
  endtask

  task automatic reset_reads();
    for (int k = 0; k < 8; k++) rdc("reset value", 5'(k * 4), 16'h0);
    @(negedge ref_clk);
    chk("count after reset", {12'h0, faultCountValue}, 16'h0);
    chk("irq after reset", {15'h0, irq}, 16'h0);
  endtask

  function automatic logic [3:0] lim_max(input logic [1:0] c);
    case (c)
      2'h0: return 4'h1;
      2'h1: return 4'h2;
      2'h2: return 4'h6;
      default: return 4'hc;
    endcase
  endfunction
  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    seedVal = $urandom(32'hd156);
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reset_reads();
    wr(5'h14, 16'h5555);
    for (int b = 0; b < 15; b++) begin
      cond = 16'h1 << b;
      monitorCond <= cond[14:0];
      settle();
      rdc("live walk", 5'h0c, cond);
      rdc("latched walk", 5'h08, cond);
      monitorCond <= 15'h0;
      settle();
      rdc("latched held", 5'h08, cond);
      chk("irq masked", {15'h0, irq}, (16'h5555 >> b) & 16'h0001);
      wr(5'h08, cond);
      rdc("latched cleared", 5'h08, 16'h0);
      @(negedge ref_clk);
      chk("irq cleared", {15'h0, irq}, 16'h0);
    end
    wr(5'h14, 16'h0);
    lat = 16'h0;
    for (int n = 0; n < 8; n++) begin
      cond = {1'b0, 15'($urandom())};
      lat = lat | cond;
      monitorCond <= cond[14:0];
      settle();
      rdc("live random", 5'h0c, cond);
      rdc("latched random", 5'h08, lat);
    end
    monitorCond <= 15'h0;
    settle();
    msk = {1'b0, 15'($urandom())};
    wr(5'h08, msk);
    rdc("partial clear", 5'h08, lat & ~msk);
    faultInAError <= 1'b1;
    settle();
    rdc("io error a", 5'h10, 16'h2000);
    faultInAError <= 1'b0;
    faultInBError <= 1'b1;
    settle();
    rdc("io error b", 5'h10, 16'h6000);
    wr(5'h18, 16'h6000);
    @(negedge ref_clk);
    chk("irq io", {15'h0, irq}, 16'h0001);
    wr(5'h18, 16'h0000);
    faultInBError <= 1'b0;
    settle();
    wr(5'h10, 16'h6000);
    rdc("io error cleared", 5'h10, 16'h0);
    prevLim = 2'h0;
    for (int c = 0; c < 4; c++) begin
      wr(5'h04, {14'h0, ~2'(c)});
      rdc("inverse limit", 5'h04, {14'h0, ~2'(c)});
      wr(5'h00, {14'h0, 2'(c) ^ 2'h1});
      @(negedge ref_clk);
      chk("limit refused", {12'h0, faultCountMax}, {12'h0, lim_max(prevLim)});
      wr(5'h00, {14'h0, 2'(c)});
      @(negedge ref_clk);
      chk("limit applied", {12'h0, faultCountMax}, {12'h0, lim_max(2'(c))});
      prevLim = 2'(c);
    end
    for (int p = 0; p < 13; p++) pulse();
    chk("count saturates", {12'h0, faultCountValue}, 16'h000c);
    chk("count reached", {15'h0, faultCountReached}, 16'h0001);
    wr(5'h04, 16'h0040);
    rdc("inverse clear bit", 5'h04, 16'h0040);
    wr(5'h00, 16'h0043);
    @(negedge ref_clk);
    chk("clear refused", {12'h0, faultCountValue}, 16'h000c);
    wr(5'h04, 16'h0000);
    wr(5'h00, 16'h0043);
    @(negedge ref_clk);
    chk("count cleared", {12'h0, faultCountValue}, 16'h0000);
    rdc("clear self-clears", 5'h00, 16'h0003);
    pulse();
    monitorCond <= 15'h7fff;
    settle();
    monitorCond <= 15'h0;
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reset_reads();
    end_of_test();
  end
endmodule
`default_nettype wire
